// ---- sln_buf2.sv ----
`timescale 1ns/10ps
`default_nettype none
module sln_buf2
  import sln_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = `BUF_DEPTH_DEF
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sln_buf2
`default_nettype wire

// ---- sln_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module sln_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // RS-232 lines
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic ta_valid,
  // RS-485 pair
  input wire logic [8:0] nd_data,
  input wire logic nd_valid,
  input wire logic rs485_driver_enable,
  input wire logic [8:0] nh_data,
  input wire logic nh_valid,
  input wire logic nh_de
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_drive_only_tx:
    assert property (rs485_driver_enable == nd_valid)
    else $error("master driver idle mismatch");
  a_addr_leads:
    assert property ($rose(rs485_driver_enable) |-> nd_data[8])
    else $error("frame not opened by address");
  a_len_follows:
    assert property (nd_valid && nd_data[8] |=>
      nd_valid && !nd_data[8] && nd_data[7:0] >= 8'h02)
    else $error("bad length after address");
  a_reply_no_addr:
    assert property (nh_valid |-> nh_de && !nh_data[8])
    else $error("bad slave char");
  a_one_talker:
    assert property (!(rs485_driver_enable && nh_de))
    else $error("both drivers on");
  a_reply_waits:
    assert property ($fell(rs485_driver_enable) |-> !nh_valid [*2])
    else $error("slave talks too soon");
  a_cts_blocks:
    assert property (cts_n [*2] |-> !ta_valid)
    else $error("sent while cts high");
  a_rts_hyst:
    assert property ($rose(rts_n) |-> rts_n [*8])
    else $error("rts released too early");
endmodule // sln_checker
`default_nettype wire

// ---- sln_defines.svh ----
`ifndef SLN_DEFINES_SVH
`define SLN_DEFINES_SVH
`define FC_HI_PCT 80
`define FC_LO_PCT 20
`define PCT_FULL 100
`define RX_DEPTH_DEF 64
`define BUF_DEPTH_DEF 2
`define XM_BLOCK_BITS 7
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021
`define MASTER_ADDR 8'h00
`define SLAVE_ADDR_MIN 8'h01
`define FRM_CRC_BYTES 8'h02
`define ADDR_FLAG 1'h1
`define DATA_FLAG 1'h0
`define MDM_CONNECT 32'h434F4E4E
`define MDM_NOCARR 32'h4E4F2043
`define REPLY_TMO_US 5000
`define CLK_HZ 10000000
`define HZ_PER_MHZ 1000000
`endif

// ---- sln_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
module sln_dev
  import sln_pkg::*;
#(
  parameter int RX_DEPTH = `RX_DEPTH_DEF,
  parameter logic [7:0] NODE_ADDR = `MASTER_ADDR,
  parameter int REPLY_TMO_CYC = `REPLY_TMO_US * (`CLK_HZ / `HZ_PER_MHZ)
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link
  sln_if.dev lnk,
  // RS-232 options
  input wire logic flow_en,
  input wire logic echo_en,
  input wire logic modem_en,
  input wire logic xmodem_active,
  // RS-232 receive buffer read
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  // RS-232 transmit
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // RS-232 status
  output logic xm_done,
  output logic xm_ok,
  output logic modem_data_mode,
  // Network request
  input wire logic net_start,
  input wire logic [7:0] net_dest,
  input wire logic [7:0] net_len,
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  output logic pay_ready,
  // Network answer
  output logic rx_pay_valid,
  output logic [7:0] rx_pay_data,
  output logic frame_ok,
  output logic frame_err,
  output logic net_timeout,
  output logic reply_req,
  output logic net_busy
);
  localparam int AW = $clog2(RX_DEPTH);
  localparam logic [AW:0] FC_HI = (AW+1)'(RX_DEPTH*`FC_HI_PCT/`PCT_FULL);
  localparam logic [AW:0] FC_LO = (AW+1)'(RX_DEPTH*`FC_LO_PCT/`PCT_FULL);
  localparam int TW = $clog2(REPLY_TMO_CYC + 1);
  localparam bit IS_MASTER = (NODE_ADDR == `MASTER_ADDR);

  logic [7:0] rxm_q [RX_DEPTH];
  logic [AW-1:0] rwr_q;
  logic [AW-1:0] rrd_q;
  logic [AW:0] fill_q;
  logic rts_q;
  logic rx_push;
  logic rx_pop;
  logic [31:0] scan_d;
  logic [31:0] scan_q;
  sln_mdm_t mdm_q;
  logic echo_pend_q;
  logic [7:0] echo_q;
  logic [7:0] ta_data_q;
  logic ta_valid_q;
  logic [`XM_BLOCK_BITS-1:0] xm_cnt_q;
  logic xm_any_q;
  logic xm_act_q;
  logic xm_done_q;
  logic xm_ok_q;

  // Receive buffer on the RS-232 side; a full buffer drops the character
  assign rx_push = lnk.tb_valid & (fill_q != (AW+1)'(RX_DEPTH));
  assign rx_pop = rd_ready & rd_valid;
  assign rd_valid = (fill_q != '0);
  assign rd_data = rxm_q[rrd_q];

  always_ff @(posedge clk_sys)
  begin
    if (rx_push)
      rxm_q[rwr_q] <= lnk.tb_data;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rwr_q <= '0;
      rrd_q <= '0;
      fill_q <= '0;
    end
    else
    begin
      if (rx_push)
        rwr_q <= (rwr_q == AW'(RX_DEPTH - 1)) ? '0 : rwr_q + 1'b1;
      if (rx_pop)
        rrd_q <= (rrd_q == AW'(RX_DEPTH - 1)) ? '0 : rrd_q + 1'b1;
      fill_q <= fill_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // Hysteresis keeps the sender from chattering on one threshold
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rts_q <= 1'b0;
    else if (!flow_en)
      rts_q <= 1'b0;
    else if (fill_q >= FC_HI)
      rts_q <= 1'b1;
    else if (fill_q < FC_LO)
      rts_q <= 1'b0;
  end
  assign lnk.rts_n = rts_q;

  // Modem scan over the last four characters read out
  assign scan_d = {scan_q[23:0], rd_data};
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_q <= '0;
      mdm_q <= MDM_CMD;
    end
    else if (!modem_en)
    begin
      scan_q <= '0;
      mdm_q <= MDM_CMD;
    end
    else if (rx_pop)
    begin
      scan_q <= scan_d;
      if (mdm_q == MDM_CMD && scan_d == `MDM_CONNECT)
        mdm_q <= MDM_DATA;
      else if (mdm_q == MDM_DATA && scan_d == `MDM_NOCARR)
        mdm_q <= MDM_CMD;
    end
  end
  assign modem_data_mode = (mdm_q == MDM_DATA);

  // One echo slot; a second arrival before CTS allows overwrites it
  assign tx_ready = !lnk.cts_n & !echo_pend_q;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      echo_pend_q <= 1'b0;
      echo_q <= 8'h00;
      ta_valid_q <= 1'b0;
      ta_data_q <= 8'h00;
    end
    else
    begin
      ta_valid_q <= 1'b0;
      if (!lnk.cts_n && echo_pend_q)
      begin
        ta_valid_q <= 1'b1;
        ta_data_q <= echo_q;
        echo_pend_q <= 1'b0;
      end
      else if (tx_valid && tx_ready)
      begin
        ta_valid_q <= 1'b1;
        ta_data_q <= tx_data;
      end
      // New arrival wins over the slot being emptied
      if (lnk.tb_valid && echo_en && !xmodem_active)
      begin
        echo_pend_q <= 1'b1;
        echo_q <= lnk.tb_data;
      end
    end
  end
  assign lnk.ta_valid = ta_valid_q;
  assign lnk.ta_data = ta_data_q;

  // XMODEM length check at the end of the transfer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xm_cnt_q <= '0;
      xm_any_q <= 1'b0;
      xm_act_q <= 1'b0;
      xm_done_q <= 1'b0;
      xm_ok_q <= 1'b0;
    end
    else
    begin
      xm_act_q <= xmodem_active;
      xm_done_q <= xm_act_q & !xmodem_active;
      if (xm_act_q && !xmodem_active)
      begin
        xm_ok_q <= xm_any_q & (xm_cnt_q == '0);
        xm_cnt_q <= '0;
        xm_any_q <= 1'b0;
      end
      else if (xmodem_active && lnk.tb_valid)
      begin
        xm_cnt_q <= xm_cnt_q + 1'b1;
        xm_any_q <= 1'b1;
      end
    end
  end
  assign xm_done = xm_done_q;
  assign xm_ok = xm_ok_q;

  // Network frame engine
  sln_net_st_t st_q;
  logic [7:0] cnt_q;
  logic [7:0] len_q;
  logic [15:0] crc_q;
  logic crc_bad_q;
  logic [TW-1:0] tmo_q;
  logic [8:0] nd_data_q;
  logic nd_valid_q;
  logic de_q;
  logic rxp_v_q;
  logic [7:0] rxp_d_q;
  logic ok_q;
  logic err_q;
  logic tmo_hit_q;
  logic b_valid;
  logic [7:0] b_data;
  logic rx_ch;
  logic [7:0] rx_b;

  sln_buf2 #(.W(8), .DEPTH(`BUF_DEPTH_DEF)) sln_buf2_inst (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(pay_valid),
    .in_data(pay_data),
    .in_ready(pay_ready),
    .out_valid(b_valid),
    .out_data(b_data),
    .out_ready(st_q == ST_TPAY)
  );

  // Own echo from the pair is blanked while our driver is on
  assign rx_ch = lnk.bus_valid & !de_q;
  assign rx_b = lnk.bus_data[7:0];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      len_q <= 8'h00;
      crc_q <= `CRC_INIT;
      crc_bad_q <= 1'b0;
      nd_valid_q <= 1'b0;
      nd_data_q <= 9'h000;
      rxp_v_q <= 1'b0;
      rxp_d_q <= 8'h00;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      tmo_hit_q <= 1'b0;
    end
    else
    begin
      nd_valid_q <= 1'b0;
      rxp_v_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      tmo_hit_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          crc_q <= `CRC_INIT;
          if (IS_MASTER && net_start)
          begin
            len_q <= net_len;
            st_q <= ST_TADDR;
          end
          else if (!IS_MASTER && rx_ch && lnk.bus_data[8] == `ADDR_FLAG
                   && rx_b == NODE_ADDR)
          begin
            crc_q <= sln_crc_byte(`CRC_INIT, rx_b);
            st_q <= ST_RLEN;
          end
        end
        ST_TADDR:
        begin
          nd_valid_q <= 1'b1;
          nd_data_q <= {`ADDR_FLAG, net_dest};
          crc_q <= sln_crc_byte(crc_q, net_dest);
          st_q <= ST_TLEN;
        end
        ST_TLEN:
        begin
          nd_valid_q <= 1'b1;
          nd_data_q <= {`DATA_FLAG, 8'(len_q + `FRM_CRC_BYTES)};
          crc_q <= sln_crc_byte(crc_q, 8'(len_q + `FRM_CRC_BYTES));
          cnt_q <= len_q;
          st_q <= (len_q == 8'h00) ? ST_TCRCH : ST_TPAY;
        end
        ST_TPAY:
        begin
          if (b_valid)
          begin
            nd_valid_q <= 1'b1;
            nd_data_q <= {`DATA_FLAG, b_data};
            crc_q <= sln_crc_byte(crc_q, b_data);
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 8'h01)
              st_q <= ST_TCRCH;
          end
        end
        ST_TCRCH:
        begin
          nd_valid_q <= 1'b1;
          nd_data_q <= {`DATA_FLAG, crc_q[15:8]};
          st_q <= ST_TCRCL;
        end
        ST_TCRCL:
        begin
          nd_valid_q <= 1'b1;
          nd_data_q <= {`DATA_FLAG, crc_q[7:0]};
          crc_q <= `CRC_INIT;
          st_q <= IS_MASTER ? ST_WAIT : ST_IDLE;
        end
        ST_WAIT, ST_RLEN:
        begin
          if (rx_ch)
          begin
            crc_q <= sln_crc_byte(crc_q, rx_b);
            cnt_q <= 8'(rx_b - `FRM_CRC_BYTES);
            if (rx_b < `FRM_CRC_BYTES)
            begin
              err_q <= 1'b1;
              st_q <= ST_IDLE;
            end
            else
              st_q <= (rx_b == `FRM_CRC_BYTES) ? ST_RCRCH : ST_RPAY;
          end
          else if (st_q == ST_WAIT && tmo_q == TW'(REPLY_TMO_CYC - 1))
          begin
            tmo_hit_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_RPAY:
        begin
          if (rx_ch)
          begin
            rxp_v_q <= 1'b1;
            rxp_d_q <= rx_b;
            crc_q <= sln_crc_byte(crc_q, rx_b);
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 8'h01)
              st_q <= ST_RCRCH;
          end
        end
        ST_RCRCH:
        begin
          if (rx_ch)
          begin
            crc_bad_q <= (rx_b != crc_q[15:8]);
            st_q <= ST_RCRCL;
          end
        end
        ST_RCRCL:
        begin
          if (rx_ch)
          begin
            if (!crc_bad_q && rx_b == crc_q[7:0])
            begin
              ok_q <= 1'b1;
              st_q <= IS_MASTER ? ST_IDLE : ST_REPLY;
            end
            else
            begin
              err_q <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_REPLY:
        begin
          crc_q <= `CRC_INIT;
          if (net_start)
          begin
            len_q <= net_len;
            st_q <= ST_TLEN;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Reply timer runs only while waiting
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      tmo_q <= '0;
    else if (st_q == ST_WAIT)
      tmo_q <= tmo_q + 1'b1;
    else
      tmo_q <= '0;
  end

  // Driver on exactly with the characters we emit
  // Payload stall releases the pair rather than hold it idle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      de_q <= 1'b0;
    else
      de_q <= (st_q inside {ST_TADDR, ST_TLEN, ST_TCRCH, ST_TCRCL})
              | (st_q == ST_TPAY && b_valid);
  end

  assign lnk.nd_valid = nd_valid_q;
  assign lnk.nd_data = nd_data_q;
  assign lnk.rs485_driver_enable = de_q;
  assign rx_pay_valid = rxp_v_q;
  assign rx_pay_data = rxp_d_q;
  assign frame_ok = ok_q;
  assign frame_err = err_q;
  assign net_timeout = tmo_hit_q;
  assign reply_req = (st_q == ST_REPLY);
  assign net_busy = (st_q != ST_IDLE) && (st_q != ST_REPLY);
endmodule // sln_dev
`default_nettype wire

// ---- sln_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module sln_host
  import sln_pkg::*;
#(
  parameter logic [7:0] HOST_ADDR = `SLAVE_ADDR_MIN
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link
  sln_if.host lnk,
  // Terminal
  input wire logic t_hold,
  input wire logic t_tx_valid,
  input wire logic [7:0] t_tx_data,
  output logic t_tx_ready,
  output logic t_rx_valid,
  output logic [7:0] t_rx_data,
  // Slave node
  output logic h_pay_valid,
  output logic [7:0] h_pay_data,
  output logic h_frame_ok,
  output logic h_frame_err,
  output logic h_reply_req,
  input wire logic h_reply_start,
  input wire logic [7:0] h_reply_len,
  input wire logic h_rp_valid,
  input wire logic [7:0] h_rp_data,
  output logic h_rp_ready
);
  logic cts_q;
  logic tbv_q;
  logic [7:0] tbd_q;
  logic trv_q;
  logic [7:0] trd_q;
  sln_net_st_t st_q;
  logic [7:0] cnt_q;
  logic [15:0] crc_q;
  logic bad_q;
  logic [8:0] nh_d_q;
  logic nh_v_q;
  logic de_q;
  logic pv_q;
  logic [7:0] pd_q;
  logic ok_q;
  logic err_q;
  logic rx_ch;
  logic [7:0] rx_b;

  // Terminal sends only while the device's RTS is low
  assign t_tx_ready = !lnk.rts_n;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cts_q <= 1'b1;
      tbv_q <= 1'b0;
      tbd_q <= 8'h00;
      trv_q <= 1'b0;
      trd_q <= 8'h00;
    end
    else
    begin
      cts_q <= t_hold;
      tbv_q <= t_tx_valid & !lnk.rts_n;
      tbd_q <= t_tx_data;
      trv_q <= lnk.ta_valid;
      trd_q <= lnk.ta_data;
    end
  end
  assign lnk.cts_n = cts_q;
  assign lnk.tb_valid = tbv_q;
  assign lnk.tb_data = tbd_q;
  assign t_rx_valid = trv_q;
  assign t_rx_data = trd_q;

  assign rx_ch = lnk.bus_valid & !de_q;
  assign rx_b = lnk.bus_data[7:0];
  assign h_rp_ready = (st_q == ST_TPAY);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      crc_q <= `CRC_INIT;
      bad_q <= 1'b0;
      nh_v_q <= 1'b0;
      nh_d_q <= 9'h000;
      pv_q <= 1'b0;
      pd_q <= 8'h00;
      ok_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      nh_v_q <= 1'b0;
      pv_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (rx_ch && lnk.bus_data[8] == `ADDR_FLAG && rx_b == HOST_ADDR
              && HOST_ADDR >= `SLAVE_ADDR_MIN)
          begin
            crc_q <= sln_crc_byte(`CRC_INIT, rx_b);
            st_q <= ST_RLEN;
          end
        end
        ST_RLEN:
        begin
          if (rx_ch)
          begin
            crc_q <= sln_crc_byte(crc_q, rx_b);
            cnt_q <= 8'(rx_b - `FRM_CRC_BYTES);
            st_q <= (rx_b < `FRM_CRC_BYTES) ? ST_IDLE :
                    (rx_b == `FRM_CRC_BYTES) ? ST_RCRCH : ST_RPAY;
          end
        end
        ST_RPAY:
        begin
          if (rx_ch)
          begin
            pv_q <= 1'b1;
            pd_q <= rx_b;
            crc_q <= sln_crc_byte(crc_q, rx_b);
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 8'h01)
              st_q <= ST_RCRCH;
          end
        end
        ST_RCRCH:
        begin
          if (rx_ch)
          begin
            bad_q <= (rx_b != crc_q[15:8]);
            st_q <= ST_RCRCL;
          end
        end
        ST_RCRCL:
        begin
          if (rx_ch)
          begin
            ok_q <= !bad_q && rx_b == crc_q[7:0];
            err_q <= bad_q || rx_b != crc_q[7:0];
            st_q <= (!bad_q && rx_b == crc_q[7:0]) ? ST_REPLY : ST_IDLE;
          end
        end
        ST_REPLY:
        begin
          crc_q <= `CRC_INIT;
          if (h_reply_start)
          begin
            cnt_q <= h_reply_len;
            st_q <= ST_TLEN;
          end
        end
        ST_TLEN:
        begin
          nh_v_q <= 1'b1;
          nh_d_q <= {`DATA_FLAG, 8'(cnt_q + `FRM_CRC_BYTES)};
          crc_q <= sln_crc_byte(crc_q, 8'(cnt_q + `FRM_CRC_BYTES));
          st_q <= (cnt_q == 8'h00) ? ST_TCRCH : ST_TPAY;
        end
        ST_TPAY:
        begin
          if (h_rp_valid)
          begin
            nh_v_q <= 1'b1;
            nh_d_q <= {`DATA_FLAG, h_rp_data};
            crc_q <= sln_crc_byte(crc_q, h_rp_data);
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 8'h01)
              st_q <= ST_TCRCH;
          end
        end
        ST_TCRCH:
        begin
          nh_v_q <= 1'b1;
          nh_d_q <= {`DATA_FLAG, crc_q[15:8]};
          st_q <= ST_TCRCL;
        end
        ST_TCRCL:
        begin
          nh_v_q <= 1'b1;
          nh_d_q <= {`DATA_FLAG, crc_q[7:0]};
          st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      de_q <= 1'b0;
    else
      de_q <= (st_q inside {ST_TLEN, ST_TPAY, ST_TCRCH, ST_TCRCL});
  end

  assign lnk.nh_valid = nh_v_q;
  assign lnk.nh_data = nh_d_q;
  assign lnk.nh_de = de_q;
  assign h_pay_valid = pv_q;
  assign h_pay_data = pd_q;
  assign h_frame_ok = ok_q;
  assign h_frame_err = err_q;
  assign h_reply_req = (st_q == ST_REPLY);
endmodule // sln_host
`default_nettype wire

// ---- sln_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sln_if;
  // RS-232 channel
  logic [7:0] ta_data;
  logic ta_valid;
  logic [7:0] tb_data;
  logic tb_valid;
  logic rts_n;
  logic cts_n;
  // RS-485 shared pair, ninth bit on top
  logic [8:0] nd_data;
  logic nd_valid;
  logic rs485_driver_enable;
  logic [8:0] nh_data;
  logic nh_valid;
  logic nh_de;
  logic [8:0] bus_data;
  logic bus_valid;
  // Wired line: only an enabled driver reaches it
  assign bus_valid = (rs485_driver_enable & nd_valid) | (nh_de & nh_valid);
  assign bus_data = rs485_driver_enable ? nd_data : nh_data;
  modport dev (output ta_data, output ta_valid, input tb_data,
    input tb_valid, output rts_n, input cts_n, output nd_data,
    output nd_valid, output rs485_driver_enable, input bus_data,
    input bus_valid);
  modport host (input ta_data, input ta_valid, output tb_data,
    output tb_valid, input rts_n, output cts_n, output nh_data,
    output nh_valid, output nh_de, input bus_data, input bus_valid);
endinterface // sln_if
`default_nettype wire

// ---- sln_pkg.sv ----
`default_nettype none
`include "sln_defines.svh"
package sln_pkg;
  typedef enum {ST_IDLE, ST_TADDR, ST_TLEN, ST_TPAY, ST_TCRCH, ST_TCRCL,
    ST_WAIT, ST_RLEN, ST_RPAY, ST_RCRCH, ST_RCRCL, ST_REPLY} sln_net_st_t;
  typedef enum {MDM_CMD, MDM_DATA} sln_mdm_t;

  function automatic logic [15:0] sln_crc_byte(input logic [15:0] crc,
                                               input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ---- sln_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_link_flow_and_network_framing_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic flow_en, t_hold, tx_valid, echo_en, modem_en, xmodem_active;
  logic rd_ready, net_start, pay_valid, t_tx_valid, h_reply_start, h_rp_valid;
  logic [7:0] tx_data, net_dest, net_len, pay_data, t_tx_data, h_reply_len;
  logic [7:0] h_rp_data, rd_data, rx_pay_data, t_rx_data, h_pay_data;
  logic rd_valid, xm_done, xm_ok, modem_data_mode, pay_ready, rx_pay_valid;
  logic frame_ok, frame_err, net_timeout, reply_req, net_busy, tx_ready;
  logic t_tx_ready, t_rx_valid, h_pay_valid, h_frame_ok, h_frame_err;
  logic h_reply_req, h_rp_ready;
  logic [8:0] q_r[$], q_t[$], q_h[$], q_m[$], q_x[$];
  int fails = 0;
  int samples_checked = 0;
  string ms[4] = '{"NO C", "CONN", "CONN", "NO C"};
  sln_if lnk();
  // Short reply timeout keeps the miss case brief
  sln_dev #(.REPLY_TMO_CYC(200)) sln_dev_inst (.*);
  sln_host #(.HOST_ADDR(8'h05)) sln_host_inst (.*);
  sln_checker sln_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .rts_n(lnk.rts_n), .cts_n(lnk.cts_n), .ta_valid(lnk.ta_valid),
    .nd_data(lnk.nd_data), .nd_valid(lnk.nd_valid),
    .rs485_driver_enable(lnk.rs485_driver_enable), .nh_data(lnk.nh_data),
    .nh_valid(lnk.nh_valid), .nh_de(lnk.nh_de));
  always #50 clk_sys = ~clk_sys;
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic take(ref logic [8:0] q[$], input logic [8:0] s, string n);
    chk(n, s, q.size() > 0 ? q.pop_front() : 9'h1FF);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic term(input logic [7:0] c, input logic echo);
    t_tx_data = c;
    t_tx_valid = 1'b1;
    q_r.push_back({1'b0, c});
    if (echo) q_t.push_back({1'b0, c});
    while (t_tx_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic rts(input logic e);
    idle(5);
    chk("rts", {8'h00, lnk.rts_n}, {8'h00, e});
  endtask
  // Valid held until the edge that sees ready
  task automatic feed(input logic m, input logic [7:0] b);
    pay_data = b;
    h_rp_data = b;
    pay_valid = m;
    h_rp_valid = !m;
    while ((m ? pay_ready : h_rp_ready) !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic net(input logic [7:0] dst, n, r);
    logic [7:0] b;
    net_dest = dst;
    net_len = n;
    net_start = 1'b1;
    idle(1);
    net_start = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      b = (dst == 8'h06) ? 8'h05 : 8'($urandom);
      if (dst == 8'h05) q_h.push_back({1'b0, b});
      feed(1'b1, b);
    end
    pay_valid = 1'b0;
    if (dst == 8'h05)
    begin
      q_h.push_back(9'h100);
      for (int k = 0; k < 300 && h_reply_req !== 1'b1; k++) idle(1);
      h_reply_len = r;
      h_reply_start = 1'b1;
      idle(1);
      h_reply_start = 1'b0;
      for (int i = 0; i < r; i++)
      begin
        b = 8'($urandom);
        q_m.push_back({1'b0, b});
        feed(1'b0, b);
      end
      h_rp_valid = 1'b0;
      q_m.push_back(9'h100);
    end
    else
      q_m.push_back(9'h102);
    for (int k = 0; k < 400 && net_busy !== 1'b0; k++) idle(1);
    idle(3);
  endtask
  always @(posedge clk_sys)
  begin
    if (h_pay_valid === 1'b1) take(q_h, {1'b0, h_pay_data}, "sl");
    if ((h_frame_ok | h_frame_err) === 1'b1)
      take(q_h, {8'h80, h_frame_err}, "sl");
    if (rx_pay_valid === 1'b1) take(q_m, {1'b0, rx_pay_data}, "ms");
    if ((frame_ok | frame_err) === 1'b1)
      take(q_m, {8'h80, frame_err}, "ms");
    if (net_timeout === 1'b1) take(q_m, 9'h102, "ms");
    if (t_rx_valid === 1'b1) take(q_t, {1'b0, t_rx_data}, "ec");
    if ((rd_valid & rd_ready) === 1'b1)
      take(q_r, {1'b0, rd_data}, "rx");
    if (xm_done === 1'b1) take(q_x, {8'h00, xm_ok}, "xm");
  end
  initial
  begin
    idle(20000);
    fails++;
    complete_run();
  end
  initial
  begin
    {flow_en, t_hold, tx_valid, tx_data} = {3'h4, 8'h00};
    {echo_en, modem_en, xmodem_active, rd_ready, net_start} = '0;
    {pay_valid, t_tx_valid, h_reply_start, h_rp_valid} = '0;
    {net_dest, net_len, pay_data, t_tx_data, h_reply_len, h_rp_data} = '0;
    void'($urandom(32'h21D809D1));
    idle(6);
    rst_b = 1'b1;
    idle(1);
    repeat (50) term(8'($urandom), 1'b0);
    t_tx_valid = 1'b0;
    rts(1'b0);
    term(8'($urandom), 1'b0);
    t_tx_valid = 1'b0;
    rts(1'b1);
    rd_ready = 1'b1;
    idle(39);
    rd_ready = 1'b0;
    rts(1'b1);
    rd_ready = 1'b1;
    idle(1);
    rd_ready = 1'b0;
    rts(1'b0);
    rd_ready = 1'b1;
    echo_en = 1'b1;
    repeat (2)
    begin
      term(8'($urandom), 1'b1);
      t_tx_valid = 1'b0;
      idle(4);
    end
    // Held CTS parks the echo and refuses user data
    t_hold = 1'b1;
    idle(2);
    term(8'($urandom), 1'b1);
    t_tx_valid = 1'b0;
    tx_data = 8'($urandom);
    tx_valid = 1'b1;
    q_t.push_back({1'b0, tx_data});
    idle(6);
    chk("cts", {8'h00, tx_ready}, 9'h000);
    t_hold = 1'b0;
    while (tx_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    tx_valid = 1'b0;
    idle(4);
    for (int n = 127; n <= 128; n++)
    begin
      xmodem_active = 1'b1;
      idle(2);
      repeat (n) term(8'($urandom), 1'b0);
      t_tx_valid = 1'b0;
      idle(4);
      q_x.push_back({8'h00, n % 128 == 0});
      xmodem_active = 1'b0;
      idle(6);
    end
    echo_en = 1'b0;
    modem_en = 1'b1;
    foreach (ms[j])
    begin
      for (int k = 0; k < 4; k++) term(ms[j][k], 1'b0);
      t_tx_valid = 1'b0;
      idle(5);
      chk("mode", {8'h00, modem_data_mode},
        9'((4'h6 >> j) & 4'h1));
    end
    net(8'h05, 8'h01, 8'h01);
    net(8'h06, 8'h02, 8'h00);
    net(8'h05, 8'(2 + $urandom % 6), 8'(1 + $urandom % 6));
    chk("req", {8'h00, reply_req}, 9'h000);
    chk("left", 9'(q_h.size() + q_m.size() + q_t.size() + q_r.size()
      + q_x.size()), 9'h000);
    complete_run();
  end
endmodule // serial_link_flow_and_network_framing_tb_top
`default_nettype wire
